// File: core/imch_pkg.sv
/*
 Constants shared by the idle-mode command handler and its pixel stage.
 Assumes a command decoder upstream that delivers whole bytes on the device clock.
*/
package imch_pkg;
    localparam logic [7:0] IMCH_CMD_IDLE_EXIT = 8'h38;
    localparam logic [7:0] IMCH_CMD_IDLE_ENTRY = 8'h39;
    localparam logic [7:0] IMCH_CMD_READ_DESC = 8'ha1;
    localparam logic IMCH_IDLE_RESET = 1'h0;
    localparam int IMCH_COLOR_BITS = 8;
    localparam int IMCH_READ_BYTES = 2;
    localparam logic [7:0] IMCH_SUPPLIER_ID_DEFAULT = 8'h5a;
    localparam logic [7:0] IMCH_MODEL_REV_DEFAULT = 8'h01;
    typedef enum logic [1:0] {IMCH_IDLE_S, IMCH_RD_FIRST_S, IMCH_RD_SECOND_S} imch_state_e;
endpackage : imch_pkg

// File: core/imch_pix_if.sv
/*
 Interface carrying the idle flag and frame tick to the pixel stage.
 Assumes both ends share CLOCK_I.
*/
`timescale 1ns/1ps
`default_nettype none
interface imch_pix_if;
    logic idle_mode;
    logic frame_start;
    modport ctrl (output idle_mode, output frame_start);
    modport pix (input idle_mode, input frame_start);
endinterface : imch_pix_if
`default_nettype wire

// File: core/imch_pixel_stage.sv
/*
 Pixel path stage: full colour or MSB-only eight-colour output.
 Assumes the idle flag and frame tick arrive on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module imch_pixel_stage #(
    parameter int CW = imch_pkg::IMCH_COLOR_BITS
) (
    input wire logic clock_i,
    input wire logic srst_i,
    imch_pix_if.pix ctl,
    input wire logic [3*CW-1:0] pix_i,
    input wire logic pix_valid_i,
    output logic [3*CW-1:0] pix_o,
    output logic pix_valid_o,
    output logic idle_active_o
);
    logic idle_active_reg;
    logic idle_active_next;
    logic [3*CW-1:0] pix_reg;
    logic [3*CW-1:0] pix_next;
    logic valid_reg;
    logic valid_next;
    logic [3*CW-1:0] pix_mask;

    // keep only the msb of each component
    generate
        for (genvar c = 0; c < 3; c++)
        begin : g_comp
            assign pix_mask[c*CW +: CW] = {pix_i[c*CW+CW-1], {(CW-1){1'b0}}};
        end
    endgenerate

    always_comb
    begin
        idle_active_next = idle_active_reg;
        // change only on a frame boundary so no frame is half reduced
        if (ctl.frame_start)
        begin
            idle_active_next = ctl.idle_mode;
        end
        valid_next = pix_valid_i;
        pix_next = pix_reg;
        if (pix_valid_i)
        begin
            // stored frame data is never touched, only this copy
            pix_next = idle_active_next ? pix_mask : pix_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            idle_active_reg <= imch_pkg::IMCH_IDLE_RESET;
            pix_reg <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            idle_active_reg <= idle_active_next;
            pix_reg <= pix_next;
            valid_reg <= valid_next;
        end
    end

    assign pix_o = pix_reg;
    assign pix_valid_o = valid_reg;
    assign idle_active_o = idle_active_reg;

    chk_msb_only: assert property (@(posedge clock_i) disable iff (srst_i)
        (pix_valid_i && idle_active_next) |=> (pix_o[CW-2:0] == '0))
        else $error("idle pixel kept low bits");
    chk_full_depth: assert property (@(posedge clock_i) disable iff (srst_i)
        (pix_valid_i && !idle_active_next) |=> (pix_o == $past(pix_i)))
        else $error("full colour pixel altered");
    chk_frame_switch: assert property (@(posedge clock_i) disable iff (srst_i)
        (!ctl.frame_start) |=> $stable(idle_active_reg))
        else $error("idle view changed mid frame");
endmodule : imch_pixel_stage
`default_nettype wire

// File: core/imch_top.sv
/*
 Idle-mode command handler: decodes idle entry/exit and the
 identification read, and drives the pixel stage.
 Assumes command bytes already framed by the serial port logic, on CLOCK_I.
*/
`timescale 1ns/1ps
`default_nettype none
module imch_top #(
    parameter logic [7:0] SUPPLIER_ID = imch_pkg::IMCH_SUPPLIER_ID_DEFAULT, // arbitrary value
    parameter logic [7:0] MODEL_REV = imch_pkg::IMCH_MODEL_REV_DEFAULT, // arbitrary value
    parameter int CW = imch_pkg::IMCH_COLOR_BITS
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    // command byte stream
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_BYTE_I,
    input wire logic SW_RESET_I,
    input wire logic SLEEP_I,
    // read-back bytes
    input wire logic RD_READY_I,
    output logic RD_VALID_O,
    output logic [7:0] RD_BYTE_O,
    // frame timing
    input wire logic FRAME_START_I,
    output logic IDLE_RATE_SEL_O,
    // pixel path
    input wire logic PIX_VALID_I,
    input wire logic [3*CW-1:0] PIX_I,
    output logic PIX_VALID_O,
    output logic [3*CW-1:0] PIX_O,
    output logic IDLE_MODE_O
);
    logic idle_reg;
    logic idle_next;
    imch_pkg::imch_state_e state_reg;
    imch_pkg::imch_state_e state_next;
    logic [7:0] rd_byte_reg;
    logic [7:0] rd_byte_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic idle_active;
    imch_pix_if pif ();

    function automatic logic is_cmd(input logic v, input logic [7:0] b, input logic [7:0] c);
        is_cmd = v && (b == c);
    endfunction : is_cmd

    always_comb
    begin
        idle_next = idle_reg;
        state_next = state_reg;
        rd_byte_next = rd_byte_reg;
        rd_valid_next = rd_valid_reg;
        // sleep plays no part in acceptance
        if (is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_EXIT))
        begin
            idle_next = 1'b0;
        end
        else if (is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY))
        begin
            idle_next = 1'b1;
        end
        case (state_reg)
            imch_pkg::IMCH_IDLE_S:
            begin
                if (is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_READ_DESC))
                begin
                    state_next = imch_pkg::IMCH_RD_FIRST_S;
                    rd_byte_next = SUPPLIER_ID;
                    rd_valid_next = 1'b1;
                end
            end
            imch_pkg::IMCH_RD_FIRST_S:
            begin
                if (RD_READY_I)
                begin
                    state_next = imch_pkg::IMCH_RD_SECOND_S;
                    rd_byte_next = MODEL_REV;
                end
            end
            imch_pkg::IMCH_RD_SECOND_S:
            begin
                if (RD_READY_I)
                begin
                    state_next = imch_pkg::IMCH_IDLE_S;
                    rd_valid_next = 1'b0;
                end
            end
            default:
            begin
                state_next = imch_pkg::IMCH_IDLE_S;
                rd_valid_next = 1'b0;
            end
        endcase
        // software reset in the same cycle as a command wins
        if (SW_RESET_I)
        begin
            idle_next = imch_pkg::IMCH_IDLE_RESET;
            state_next = imch_pkg::IMCH_IDLE_S;
            rd_byte_next = 8'h00;
            rd_valid_next = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            idle_reg <= imch_pkg::IMCH_IDLE_RESET;
            state_reg <= imch_pkg::IMCH_IDLE_S;
            rd_byte_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            idle_reg <= idle_next;
            state_reg <= state_next;
            rd_byte_reg <= rd_byte_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign pif.idle_mode = idle_reg;
    assign pif.frame_start = FRAME_START_I;

    imch_pixel_stage #(
        .CW(CW)
    ) u_pix (
        .clock_i(CLOCK_I),
        .srst_i(SRST_I | SW_RESET_I),
        .ctl(pif),
        .pix_i(PIX_I),
        .pix_valid_i(PIX_VALID_I),
        .pix_o(PIX_O),
        .pix_valid_o(PIX_VALID_O),
        .idle_active_o(idle_active)
    );

    assign RD_VALID_O = rd_valid_reg;
    assign RD_BYTE_O = rd_byte_reg;
    assign IDLE_MODE_O = idle_reg;
    // idle frame rate only when the panel view is reduced
    assign IDLE_RATE_SEL_O = idle_active;

    chk_exit_clears: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_EXIT) |=> !IDLE_MODE_O)
        else $error("idle exit not taken");
    chk_entry_sets: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY) && !SW_RESET_I)
        |=> IDLE_MODE_O)
        else $error("idle entry not taken");
    chk_exit_noop: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (!IDLE_MODE_O && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_EXIT)
        && state_reg == imch_pkg::IMCH_IDLE_S) |=> (!IDLE_MODE_O && !RD_VALID_O))
        else $error("exit changed state");
    chk_entry_noop: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (IDLE_MODE_O && !SW_RESET_I && state_reg == imch_pkg::IMCH_IDLE_S
        && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY))
        |=> (IDLE_MODE_O && !RD_VALID_O))
        else $error("entry changed state");
    chk_reset_off: assert property (@(posedge CLOCK_I)
        (SRST_I || SW_RESET_I) |=> !IDLE_MODE_O)
        else $error("idle on after reset");
    chk_sleep_accept: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (SLEEP_I && !SW_RESET_I
        && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY)) |=> IDLE_MODE_O)
        else $error("command refused in sleep");
    chk_read_pair: assert property (@(posedge CLOCK_I) disable iff (SRST_I || SW_RESET_I)
        (state_reg == imch_pkg::IMCH_IDLE_S
        && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_READ_DESC))
        |=> (RD_VALID_O && RD_BYTE_O == SUPPLIER_ID))
        else $error("first id byte wrong");
    chk_read_second: assert property (@(posedge CLOCK_I) disable iff (SRST_I || SW_RESET_I)
        (state_reg == imch_pkg::IMCH_RD_FIRST_S && RD_READY_I)
        |=> (RD_VALID_O && RD_BYTE_O == MODEL_REV))
        else $error("second id byte wrong");
    // read-back bytes stand until taken, then the read ends
    chk_read_hold: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (state_reg == imch_pkg::IMCH_RD_FIRST_S && !RD_READY_I && !SW_RESET_I)
        |=> (RD_VALID_O && RD_BYTE_O == SUPPLIER_ID))
        else $error("first id byte did not stand");
    chk_read_done: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (state_reg == imch_pkg::IMCH_RD_SECOND_S && RD_READY_I)
        |=> !RD_VALID_O)
        else $error("read did not end after two bytes");
    chk_read_sleep: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (SLEEP_I && !SW_RESET_I && state_reg == imch_pkg::IMCH_IDLE_S
        && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_READ_DESC)) |=> RD_VALID_O)
        else $error("read refused in sleep");
    // panel rate follows the commanded mode from the next frame on
    chk_rate_follows: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (FRAME_START_I && !SW_RESET_I) |=> (IDLE_RATE_SEL_O == $past(IDLE_MODE_O)))
        else $error("frame rate not following idle mode");
    chk_rate_frame_only: assert property (@(posedge CLOCK_I)
        disable iff (SRST_I || SW_RESET_I) !FRAME_START_I |=> $stable(IDLE_RATE_SEL_O))
        else $error("frame rate changed mid frame");

    cov_enter: cover property (@(posedge CLOCK_I) $rose(IDLE_MODE_O));
    cov_exit: cover property (@(posedge CLOCK_I) $fell(IDLE_MODE_O));
    cov_read: cover property (@(posedge CLOCK_I)
        state_reg == imch_pkg::IMCH_RD_SECOND_S && RD_READY_I);
    cov_sleep_cmd: cover property (@(posedge CLOCK_I)
        SLEEP_I && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY));
    cov_sw_override: cover property (@(posedge CLOCK_I)
        SW_RESET_I && is_cmd(CMD_VALID_I, CMD_BYTE_I, imch_pkg::IMCH_CMD_IDLE_ENTRY));
endmodule : imch_top
`default_nettype wire

// File: sim/imch_host_model.sv
/*
 Host controller model: sends single-byte commands and clocks out read bytes.
 Assumes the device samples on the rising edge of clock_i; the host drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module imch_host_model (
    // clock
    input wire logic clock_i,
    // command strobe
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o,
    // read-back handshake
    output logic rd_ready_o,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_byte_i
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_byte_o = 8'h00;
        rd_ready_o = 1'b0;
    end
    // no parameter bytes follow; released byte is scrambled
    task automatic send(input logic [7:0] code);
    begin
        @(negedge clock_i);
        cmd_valid_o = 1'b1;
        cmd_byte_o = code;
        @(negedge clock_i);
        cmd_valid_o = 1'b0;
        cmd_byte_o = ~code;
    end
    endtask : send
    // both bytes clocked out, optional stall before each
    task automatic take(input int stall, output logic [15:0] got);
        int w;
    begin
        got = 16'h0000;
        for (int k = 0; k < 2; k++)
        begin
            if (stall > 0)
            begin
                rd_ready_o = 1'b0;
                repeat (stall) @(negedge clock_i);
            end
            rd_ready_o = 1'b1;
            w = 0;
            @(posedge clock_i);
            while (rd_valid_i !== 1'b1 && w < 20)
            begin
                @(posedge clock_i);
                w++;
            end
            got = {got[7:0], rd_byte_i};
            @(negedge clock_i);
        end
        rd_ready_o = 1'b0;
    end
    endtask : take
endmodule : imch_host_model
`default_nettype wire

// File: sim/idle_mode_command_handler_tb_top.sv
/*
 Self-checking bench for the idle-mode command handler with a host model.
 Assumes default parameters: eight bits per colour, identity bytes from the package.
*/
`timescale 1ns/1ps
`default_nettype none
module idle_mode_command_handler_tb_top;
    logic clock_i, srst_i, sw_rst, sleep, fs, pv, cv, rdy, rd_v, pix_v, idle, rate;
    logic [7:0] cb, rd_b;
    logic [23:0] pix_in, pix_out;
    logic [15:0] got;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // sleep, code, expected idle state
    localparam logic [9:0] ROWS [8] = '{{1'b0, 8'h39, 1'b1}, {1'b0, 8'h39, 1'b1},
        {1'b0, 8'h38, 1'b0}, {1'b0, 8'h38, 1'b0}, {1'b1, 8'h39, 1'b1}, {1'b1, 8'h38, 1'b0},
        {1'b0, 8'h55, 1'b0}, {1'b0, 8'h39, 1'b1}};
    imch_top uut (.CLOCK_I(clock_i), .SRST_I(srst_i), .CMD_VALID_I(cv), .CMD_BYTE_I(cb),
        .SW_RESET_I(sw_rst), .SLEEP_I(sleep), .RD_READY_I(rdy), .RD_VALID_O(rd_v),
        .RD_BYTE_O(rd_b), .FRAME_START_I(fs), .IDLE_RATE_SEL_O(rate), .PIX_VALID_I(pv),
        .PIX_I(pix_in), .PIX_VALID_O(pix_v), .PIX_O(pix_out), .IDLE_MODE_O(idle));
    imch_host_model host (.clock_i(clock_i), .cmd_valid_o(cv), .cmd_byte_o(cb),
        .rd_ready_o(rdy), .rd_valid_i(rd_v), .rd_byte_i(rd_b));
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic give_verdict;
    begin
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : give_verdict
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask : check
    // one pixel, optional frame start, checked a cycle later
    task automatic pix(input logic [23:0] p, input logic f, input logic v, input logic [23:0] e,
        input logic r);
    begin
        @(negedge clock_i);
        pv = v;
        pix_in = p;
        fs = f;
        @(negedge clock_i);
        pv = 1'b0;
        fs = 1'b0;
        pix_in = ~p;
        check(pix_out, e);
        check(pix_v, v);
        check(rate, r);
    end
    endtask : pix
    initial
    begin
        srst_i = 1'b1;
        sw_rst = 1'b0;
        sleep = 1'b0;
        fs = 1'b0;
        pv = 1'b0;
        pix_in = 24'h000000;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        srst_i = 1'b0;
        check({idle, rate, rd_v, pix_v}, 4'h0);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clock_i);
            sleep = ROWS[i][9];
            host.send(ROWS[i][8:1]);
            check(idle, ROWS[i][0]);
        end
        sleep = 1'b0;
        // idle commanded: view waits for frame start
        pix(24'ha5c37e, 1'b0, 1'b1, 24'ha5c37e, 1'b0);
        pix(24'ha5c37e, 1'b1, 1'b1, 24'h808000, 1'b1);
        for (int c = 0; c < 8; c++)
            pix({c[2], 7'h7f, c[1], 7'h7f, c[0], 7'h7f}, 1'b0, 1'b1,
                {c[2], 7'h00, c[1], 7'h00, c[0], 7'h00}, 1'b1);
        host.send(8'h38);
        pix(24'ha5c37e, 1'b0, 1'b1, 24'h808000, 1'b1);
        pix(24'ha5c37e, 1'b1, 1'b1, 24'ha5c37e, 1'b0);
        // no valid pixel: panel output holds
        pix(24'h123456, 1'b0, 1'b0, 24'ha5c37e, 1'b0);
        // second read request during a read is ignored
        sleep = 1'b1;
        host.send(8'ha1);
        host.send(8'ha1);
        host.take(3, got);
        check(got, {imch_pkg::IMCH_SUPPLIER_ID_DEFAULT, imch_pkg::IMCH_MODEL_REV_DEFAULT});
        check(rd_v, 1'b0);
        host.send(8'ha1);
        host.take(0, got);
        check(got, {imch_pkg::IMCH_SUPPLIER_ID_DEFAULT, imch_pkg::IMCH_MODEL_REV_DEFAULT});
        // software reset, then hardware reset mid-run
        host.send(8'h39);
        pix(24'hffffff, 1'b1, 1'b1, 24'h808080, 1'b1);
        // reset held over a second edge that also carries an entry command
        sw_rst = 1'b1;
        host.send(8'h39);
        sw_rst = 1'b0;
        check({idle, rate, pix_v}, 3'h0);
        check(pix_out, 24'h000000);
        host.send(8'h39);
        srst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        check({idle, rate, rd_v}, 3'h0);
        host.send(8'h39);
        check(idle, 1'b1);
        give_verdict();
    end
endmodule : idle_mode_command_handler_tb_top
`default_nettype wire
